//--- steer_asserts.sv
// Checker of the write link and the device outputs
`timescale 1ns/10ps
module steer_asserts #(
	parameter int LATENCY = 10,
	parameter int SETTLE = 5,
	parameter int GAP = 20
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic wr,
	input wire logic [2:0] addr,
	input wire logic [15:0] data,
	input wire logic [25:0] active_word,
	input wire logic steering,
	input wire logic settled,
	input wire logic out_enable
);
	localparam int LO = LATENCY - 1;
	localparam int HI = LATENCY + 2;
	localparam int S_LO = SETTLE - 1;
	localparam int S_HI = SETTLE + 1;
	logic [15:0] lo;
	logic [25:0] pend;
	int gap;
	wire lsw = wr && addr == steer_pkg::OFF_LSW;
	wire msw = wr && addr == steer_pkg::OFF_MSW;
	// Starts saturated so the first pair is never held against the rate
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lo <= '0;
			pend <= '0;
			gap <= GAP;
		end else begin
			if (lsw)
				lo <= data;
			if (msw)
				pend <= {data[9:0], lo};
			gap <= msw ? 0 : (gap < GAP ? gap + 1 : gap);
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence upper_s;
		msw;
	endsequence
	sequence pair_s;
		lsw ##1 msw;
	endsequence
	pair_order_a: assert property (lsw |=> msw)
		else $error("upper write missing");
	upper_after_a: assert property (msw |-> $past(lsw))
		else $error("upper write without lower");
	update_rate_a: assert property (lsw |-> gap + 2 >= GAP)
		else $error("updates too close");
	pending_hold_a: assert property (pair_s |=> $stable(active_word)[*8])
		else $error("offset applied early");
	start_latency_a: assert property (upper_s |-> ##[LO:HI] $rose(steering))
		else $error("pull start late");
	applied_word_a: assert property ($rose(steering) |-> active_word == pend)
		else $error("applied word wrong");
	settle_time_a: assert property ($rose(steering) |-> ##[S_LO:S_HI] (settled && !steering))
		else $error("settle time wrong");
	oe_follow_a: assert property (msw |=> out_enable == $past(data[10]))
		else $error("enable not taken");
	oe_hold_a: assert property (!msw |=> $stable(out_enable))
		else $error("enable changed alone");
	oe_reset_a: assert property ($fell(rst) |-> !out_enable)
		else $error("output on after reset");
endmodule

//--- steer_device.sv
// Steering device: control word staging, delayed apply, settle and output enable
//
// Operation
// - Host scales ppm to signed control word
// - Word scaled against selected pull span
// - Host writes lower word, then upper
// - Host sets enable with upper word
// - Host limits updates to 38 kHz
// - Pull starts within start latency
// - Settles within settle time after start
// - Enable bit drives or disables output
// - Output disabled at power-up
// - Host may stream four bytes
// - Lower word pending until upper written
// - 26-bit signed offset, reset zero
// - Pin mode ignores software enable writes
`timescale 1ns/10ps
module steer_device #(
	parameter bit SW_OE = 1'b1,
	parameter int LATENCY = steer_pkg::LATENCY_CYC,
	parameter int SETTLE = steer_pkg::SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	steer_if.device link,
	input wire logic oe_pin,
	output logic [steer_pkg::WORD_W-1:0] active_word,
	output logic [steer_pkg::SPAN_W-1:0] pull_span,
	output logic [steer_pkg::WORD_W+steer_pkg::SPAN_W-1:0] steer_target,
	output logic steering,
	output logic settled,
	output logic out_enable
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_PULL = 3'b100
	} phase_t;
	typedef struct packed {
		phase_t phase;
		logic [15:0] lsw_pend;
		logic [25:0] staged;
		logic [25:0] active;
		logic [3:0] span;
		logic [3:0] span_staged;
		logic oe_reg;
		logic oe_pin_m;
		logic oe_pin_s;
		logic out_en;
		logic steering;
		logic settled;
		logic [29:0] target;
	} state_t;
	state_t s, next_s;
	logic t_load;
	logic [steer_pkg::CNT_W-1:0] t_count;
	logic t_busy;
	logic t_done;
	steer_timer #(.W(steer_pkg::CNT_W)) timer (
		.clk(clk),
		.rst(rst),
		.load(t_load),
		.count(t_count),
		.busy(t_busy),
		.done(t_done)
	);
	// Applied offset is the signed word tagged with span code for the analog side
	function automatic logic [29:0] pack_target(logic [3:0] sp, logic [25:0] w);
		return {sp, w};
	endfunction
	always_comb begin
		next_s = s;
		t_load = 1'b0;
		t_count = '0;
		next_s.oe_pin_m = oe_pin;
		next_s.oe_pin_s = s.oe_pin_m;
		if (link.wr) begin
			if (link.addr == steer_pkg::OFF_LSW) begin
				next_s.lsw_pend = link.data;
			end else if (link.addr == steer_pkg::OFF_MSW) begin
				// Whole word moves at once so no half-old offset is seen
				next_s.staged = {link.data[steer_pkg::MSW_HI:steer_pkg::MSW_LO],
					s.lsw_pend};
				next_s.span_staged = s.span;
				if (SW_OE) begin
					next_s.oe_reg = link.data[steer_pkg::OE_BIT];
				end
				next_s.phase = ST_WAIT;
				t_load = 1'b1;
				t_count = steer_pkg::CNT_W'(LATENCY);
			end else if (link.addr == steer_pkg::OFF_SPAN) begin
				next_s.span = link.data[steer_pkg::SPAN_HI:0];
			end
		end
		if (!t_load) begin
			case (s.phase)
				ST_WAIT: begin
					if (t_done) begin
						next_s.active = s.staged;
						next_s.target = pack_target(s.span_staged, s.staged);
						next_s.steering = 1'b1;
						next_s.settled = 1'b0;
						next_s.phase = ST_PULL;
						t_load = 1'b1;
						t_count = steer_pkg::CNT_W'(SETTLE);
					end
				end
				ST_PULL: begin
					if (t_done) begin
						next_s.steering = 1'b0;
						next_s.settled = 1'b1;
						next_s.phase = ST_IDLE;
					end
				end
				default: begin
					next_s.phase = ST_IDLE;
				end
			endcase
		end
		// In software mode the driver follows the bit on the same edge that captures the upper write; in pin mode it follows the synced pin
		next_s.out_en = SW_OE ? next_s.oe_reg : s.oe_pin_s;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s.phase <= ST_IDLE;
			s.lsw_pend <= steer_pkg::LSW_RESET;
			s.staged <= '0;
			s.active <= '0;
			s.span <= steer_pkg::SPAN_RESET;
			s.span_staged <= steer_pkg::SPAN_RESET;
			s.oe_reg <= steer_pkg::OE_RESET;
			s.oe_pin_m <= 1'b0;
			s.oe_pin_s <= 1'b0;
			s.out_en <= 1'b0;
			s.steering <= 1'b0;
			s.settled <= 1'b1;
			s.target <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign active_word = s.active;
	assign pull_span = s.span;
	assign steer_target = s.target;
	assign steering = s.steering;
	assign settled = s.settled;
	assign out_enable = s.out_en;
endmodule

//--- steer_host.sv
// Host controller: Wishbone registers to ordered control-word writes
`timescale 1ns/10ps
module steer_host #(
	parameter int GAP = steer_pkg::UPDATE_GAP_CYC
) (
	input wire logic clk,
	input wire logic rst,
	steer_if.host link,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o
);
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_LSW = 4'b0010,
		H_MSW = 4'b0100,
		H_SPAN = 4'b1000
	} hstate_t;
	typedef struct packed {
		hstate_t st;
		logic [25:0] word;
		logic oe;
		logic [3:0] span;
		logic busy;
		logic [15:0] gap;
		logic wr;
		logic [2:0] addr;
		logic [15:0] data;
		logic ack;
		logic [31:0] rdat;
	} state_t;
	state_t s, next_s;
	logic req;
	always_comb begin
		next_s = s;
		req = cyc_i && stb_i && !s.ack;
		next_s.ack = req;
		next_s.wr = 1'b0;
		if (s.gap != 16'h0000) begin
			next_s.gap = s.gap - 16'h0001;
		end
		next_s.rdat = 32'h00000000;
		if (req) begin
			if (adr_i == steer_pkg::HR_CMD) begin
				// Command: bits 25:0 word, bit 26 enable, bit 31 go
				if (we_i && !s.busy && sel_i == 4'hf) begin
					next_s.word = dat_i[25:0];
					next_s.oe = dat_i[26];
					if (dat_i[31]) begin
						next_s.busy = 1'b1;
					end
				end
				next_s.rdat = {5'h00, s.oe, s.word};
			end else if (adr_i == steer_pkg::HR_STAT) begin
				next_s.rdat = {31'h00000000, s.busy};
			end else if (adr_i == steer_pkg::HR_SPAN) begin
				if (we_i && sel_i[0] && s.st == H_IDLE) begin
					next_s.span = dat_i[3:0];
					next_s.st = H_SPAN;
				end
				next_s.rdat = {28'h0000000, s.span};
			end else begin
				next_s.rdat = steer_pkg::WB_UNMAPPED;
			end
		end
		case (s.st)
			H_IDLE: begin
				// Spacing keeps updates under the device's rate ceiling
				if (s.busy && s.gap == 16'h0000) begin
					next_s.st = H_LSW;
				end
			end
			H_LSW: begin
				next_s.wr = 1'b1;
				next_s.addr = steer_pkg::OFF_LSW;
				next_s.data = s.word[15:0];
				next_s.st = H_MSW;
			end
			H_MSW: begin
				next_s.wr = 1'b1;
				next_s.addr = steer_pkg::OFF_MSW;
				next_s.data = {5'h00, s.oe, s.word[25:16]};
				next_s.busy = 1'b0;
				next_s.gap = 16'(GAP);
				next_s.st = H_IDLE;
			end
			H_SPAN: begin
				next_s.wr = 1'b1;
				next_s.addr = steer_pkg::OFF_SPAN;
				next_s.data = {12'h000, s.span};
				next_s.st = H_IDLE;
			end
			default: begin
				next_s.st = H_IDLE;
			end
		endcase
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.st <= H_IDLE;
		end else begin
			s <= next_s;
		end
	end
	assign link.wr = s.wr;
	assign link.addr = s.addr;
	assign link.data = s.data;
	assign dat_o = s.rdat;
	assign ack_o = s.ack;
endmodule

//--- steer_if.sv
// Register write link between host controller and steering device
`timescale 1ns/10ps
interface steer_if;
	logic wr;
	logic [steer_pkg::ADDR_W-1:0] addr;
	logic [steer_pkg::DATA_W-1:0] data;
	modport device (input wr, input addr, input data);
	modport host (output wr, output addr, output data);
endinterface

//--- steer_pkg.sv
// Shared constants for the frequency steering link
package steer_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 16;
	localparam int WORD_W = 26;
	localparam int SPAN_W = 4;
	localparam logic [2:0] OFF_LSW = 3'h0;
	localparam logic [2:0] OFF_MSW = 3'h1;
	localparam logic [2:0] OFF_SPAN = 3'h2;
	localparam int MSW_LO = 0;
	localparam int MSW_HI = 9;
	localparam int OE_BIT = 10;
	localparam int SPAN_HI = 3;
	localparam logic [15:0] LSW_RESET = 16'h0000;
	localparam logic [9:0] MSW_RESET = 10'h000;
	localparam logic [3:0] SPAN_RESET = 4'h0;
	localparam logic OE_RESET = 1'b0;
	localparam int CLK_MHZ = 20;
	localparam int LATENCY_US = 103;
	localparam int LATENCY_CYC = LATENCY_US * CLK_MHZ;
	localparam int SETTLE_US = 16;
	localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
	localparam int UPDATE_HZ = 38000;
	localparam int UPDATE_GAP_CYC = (CLK_MHZ * 1000000 + UPDATE_HZ - 1) / UPDATE_HZ;
	localparam logic [25:0] HALF_SCALE = 26'h1ffffff;
	localparam int CNT_W = 16;
	localparam logic [31:0] WB_UNMAPPED = 32'hdeadbeef;
	localparam logic [3:0] HR_CMD = 4'h0;
	localparam logic [3:0] HR_STAT = 4'h4;
	localparam logic [3:0] HR_SPAN = 4'h8;
endpackage

//--- steer_timer.sv
// Down counter giving one pulse when a load has expired
`timescale 1ns/10ps
module steer_timer #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] count,
	output logic busy,
	output logic done
);
	typedef struct packed {
		logic [W-1:0] cnt;
		logic busy;
		logic done;
	} state_t;
	state_t s, next_s;
	always_comb begin
		next_s = s;
		next_s.done = 1'b0;
		if (load) begin
			next_s.cnt = count;
			next_s.busy = 1'b1;
		end else if (s.busy) begin
			if (s.cnt <= W'(1)) begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end else begin
				next_s.cnt = s.cnt - W'(1);
			end
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	assign busy = s.busy;
	assign done = s.done;
endmodule

//--- tb_freq_steer_and_sw_oe.sv
// Self-checking bench of host and device joined by the write link
`timescale 1ns/10ps
module tb_freq_steer_and_sw_oe;
	logic clk, rst, cyc, stb, we, ack, oe_pin, steering, settled, oe, oe_p;
	logic [3:0] adr, sel, ps;
	logic [31:0] dat, q, dat_o;
	logic [25:0] aw, aw_p;
	logic [29:0] tgt, tgt_p;
	logic [3:0] ps_p;
	logic steering_p, settled_p;
	int errors = 0, n_compared = 0, seed = 32'h32d4;
	steer_if link();
	steer_host #(.GAP(20)) u_steer_host(.clk(clk), .rst(rst), .link(link.host), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack));
	steer_device #(.LATENCY(10), .SETTLE(5)) u_steer_device(.clk(clk), .rst(rst),
		.link(link.device), .oe_pin(oe_pin), .active_word(aw), .pull_span(ps),
		.steer_target(tgt), .steering(steering), .settled(settled), .out_enable(oe));
	// Pin-mode twin listening to the same link
	steer_device #(.SW_OE(1'h0), .LATENCY(10), .SETTLE(5)) u_steer_device_pin(.clk(clk),
		.rst(rst), .link(link.device), .oe_pin(oe_pin), .active_word(aw_p), .pull_span(ps_p),
		.steer_target(tgt_p), .steering(steering_p), .settled(settled_p), .out_enable(oe_p));
	steer_asserts #(.LATENCY(10), .SETTLE(5), .GAP(20)) u_steer_asserts(.clk(clk), .rst(rst),
		.wr(link.wr), .addr(link.addr), .data(link.data), .active_word(aw),
		.steering(steering), .settled(settled), .out_enable(oe));
	function automatic logic [25:0] ctl(input int ppm, input int range);
		return 26'(int'(33554431.0 * ppm / range));
	endfunction
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task bus(input logic w_en, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w_en;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
			@(negedge clk);
		end while (ack !== 1'h1 && n < 50);
		if (n >= 50)
			errors++;
		// Answer read mid-cycle, request held through the edge that samples it
		q = dat_o;
		@(posedge clk);
		cyc <= 1'h0;
		stb <= 1'h0;
		@(posedge clk);
	endtask
	task steer(input logic [25:0] w, input logic en, input logic [3:0] sp);
		int n;
		n = 0;
		bus(1'h1, steer_pkg::HR_SPAN, {28'h0, sp});
		bus(1'h1, steer_pkg::HR_CMD, {1'h1, 4'h0, en, w});
		bus(1'h0, steer_pkg::HR_STAT, 32'h0);
		chk(q[0], 32'h1);
		// Partial select is refused, so the first word must win
		sel <= 4'h7;
		bus(1'h1, steer_pkg::HR_CMD, {1'h1, 4'h0, ~en, ~w});
		sel <= 4'hf;
		bus(1'h0, steer_pkg::HR_CMD, 32'h0);
		chk(q[26:0], {en, w});
		do begin
			bus(1'h0, steer_pkg::HR_STAT, 32'h0);
			n++;
		end while (q[0] !== 1'h0 && n < 40);
		repeat (25) @(posedge clk);
		chk(aw, w);
		chk(ps, sp);
		chk(tgt, {sp, w});
		chk({steering, settled}, 32'h1);
		chk(oe, en);
		chk(aw_p, w);
		chk(oe_p, oe_pin);
		chk(ps_p, sp);
		chk(tgt_p, {sp, w});
		chk({steering_p, settled_p}, 32'h1);
	endtask
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		close_out;
	end
	initial begin
		rst = 1'h1;
		cyc = 1'h0;
		stb = 1'h0;
		we = 1'h0;
		adr = 4'h0;
		sel = 4'hf;
		dat = 32'h0;
		oe_pin = 1'h0;
		repeat (4) @(posedge clk);
		chk(aw, 32'h0);
		chk({oe, settled}, 32'h1);
		rst <= 1'h0;
		@(posedge clk);
		steer(ctl(90, 200), 1'h1, 4'h5);
		steer(ctl(-50, 200), 1'h0, 4'hf);
		steer(26'h1ffffff, 1'h1, 4'h0);
		steer(26'h2000000, 1'h1, 4'h9);
		for (int i = 0; i < 6; i++) begin
			oe_pin <= 1'($random(seed));
			steer(26'($random(seed)), 1'($random(seed)), 4'($random(seed)));
		end
		bus(1'h0, 4'hc, 32'h0);
		chk(q, steer_pkg::WB_UNMAPPED);
		close_out;
	end
endmodule
